// ===== rtl/mtsc_defs.svh
// Offsets, field positions, reset values and codes of the multiturn state and period block.
`ifndef MTSC_DEFS_SVH
`define MTSC_DEFS_SVH
`define MTSC_OFS_PERIOD_CFG 8'h02
`define MTSC_OFS_SCAN_CFG 8'h04
`define MTSC_OFS_STREAM_CFG 8'h05
`define MTSC_RST_CFG 8'h00
`define MTSC_POLE_LSB 0
`define MTSC_POLE_MSB 1
`define MTSC_ON_AXIS_ENABLE_BIT 2
`define MTSC_PERIOD_OUT_BIT 6
`define MTSC_POLE_ON_AXIS_ENABLE_REQ 2'h1
`define MTSC_SLAVE_ADDR 7'h61
`define MTSC_MAX_TRIES 2'h3
`define MTSC_SECTORS 11'h008
`define MTSC_PERIOD_LSBS 8
`endif

// ===== rtl/mtsc_pkg.sv
// Types shared by the multiturn state and period block.
package mtsc_pkg;
  typedef enum logic [2:0] {
    ST_POWER_ON,
    ST_ACTIVE,
    ST_BATTERY,
    ST_NO_MAGNET,
    ST_SLEEP
  } mtsc_state_type;
  typedef enum logic [2:0] {
    BOOT_IDLE,
    BOOT_LOAD,
    BOOT_RUN,
    BOOT_FAIL
  } mtsc_boot_type;
endpackage

// ===== rtl/mtsc_core.sv
// Working states, startup sequencing and period counting of the multiturn counter.
// Notes on behaviour
// - Working states ignored in parallel mode.
// - Reset or preset enters power-on, readout invalid.
// - Active state tracks fast, readout valid.
// - Battery state tracks, no readout.
// - Low field enters no-magnet, slow, error.
// - Sleep on command stops tracking, error.
// - Invalid readout returns all ones outside parallel mode.
// - Register access whenever main supply is on.
// - Startup begins on battery; failure drives error.
// - Serial preset triggers configuration load.
// - Good load runs configured mode while battery.
// - Three failed loads stop and flag error.
// - Readout served by one interface only.
// - Slave-mode preset routes readout, skips load.
// - Slave answers fixed seven-bit address.
// - Parallel preset requests position then idles.
// - Pole-width field selects scanning mode.
// - Period code plus one per revolution.
// - Eight sync sectors spread over revolution.
// - Period output takes eight LSBs, 32-bit counter.
// - On-axis bit needs pole-width code one.
`timescale 1ns/1ns
`include "mtsc_defs.svh"
module mtsc_core #(
  parameter int MT_WIDTH = 40
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_main_supply,
  input wire logic i_battery_ok,
  input wire logic i_low_field,
  input wire logic i_preset,
  input wire logic i_parallel_mode,
  input wire logic i_slave_mode,
  input wire logic i_sleep_cmd,
  input wire logic i_clear_status_cmd,
  input wire logic i_battery_fault,
  input wire logic i_period_tick,
  input wire logic i_dir_down,
  input wire logic i_cfg_load_done,
  input wire logic i_cfg_load_ok,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [6:0] i_twi_addr,
  input wire logic i_twi_addr_valid,
  output logic [7:0] o_reg_rdata,
  output logic o_cfg_load_start,
  output logic o_error_out_n,
  output logic o_track_en,
  output logic o_track_fast,
  output logic o_readout_valid,
  output logic o_readout_on_twi,
  output logic o_twi_ack,
  output logic [MT_WIDTH-1:0] o_position,
  output logic [4:0] o_state_flags,
  output logic [2:0] o_sync_bits,
  output logic [1:0] o_pole_width_select,
  output logic o_on_axis_enable,
  output logic o_cfg_conflict,
  output logic o_par_idle
);
  // Pins from the outside world are synchronised; the first stage is read by nothing else.
  logic [6:0] sync1_r;
  logic [6:0] sync2_r;
  logic main_s, batt_s, low_s, pre_s, par_s, slv_s, bfault_s;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_r <= 7'h00;
      sync2_r <= 7'h00;
    end else begin
      sync1_r <= {i_main_supply, i_battery_ok, i_low_field, i_preset, i_parallel_mode,
                  i_slave_mode, i_battery_fault};
      sync2_r <= sync1_r;
    end
  end
  assign {main_s, batt_s, low_s, pre_s, par_s, slv_s, bfault_s} = sync2_r;

  logic pre_d_r;
  logic pre_rise;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) pre_d_r <= 1'b0;
    else pre_d_r <= pre_s;
  end
  assign pre_rise = pre_s & ~pre_d_r;

  // Configuration registers; the scan and period fields steer tracking and counting.
  logic [7:0] period_count_config_r;
  logic [7:0] scan_mode_config_r;
  logic [7:0] stream_output_config_r;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      period_count_config_r <= `MTSC_RST_CFG;
      scan_mode_config_r <= `MTSC_RST_CFG;
      stream_output_config_r <= `MTSC_RST_CFG;
    end else if (i_reg_wr && main_s) begin
      case (i_reg_addr)
        `MTSC_OFS_PERIOD_CFG: period_count_config_r <= i_reg_wdata;
        `MTSC_OFS_SCAN_CFG: scan_mode_config_r <= i_reg_wdata;
        `MTSC_OFS_STREAM_CFG: stream_output_config_r <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  // Startup: a preset starts a load unless slave mode takes over; three tries at most.
  mtsc_pkg::mtsc_boot_type boot_r;
  logic [1:0] tries_r;
  logic twi_route_r;
  logic boot_fail;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      boot_r <= mtsc_pkg::BOOT_IDLE;
      tries_r <= 2'h0;
      twi_route_r <= 1'b0;
    end else if (pre_rise && slv_s) begin
      boot_r <= mtsc_pkg::BOOT_RUN;
      twi_route_r <= 1'b1;
    end else if (pre_rise && batt_s && main_s) begin
      boot_r <= mtsc_pkg::BOOT_LOAD;
      tries_r <= 2'h0;
      twi_route_r <= 1'b0;
    end else begin
      case (boot_r)
        mtsc_pkg::BOOT_IDLE: ;
        mtsc_pkg::BOOT_LOAD: begin
          if (i_cfg_load_done) begin
            if (i_cfg_load_ok) boot_r <= mtsc_pkg::BOOT_RUN;
            else if (tries_r == `MTSC_MAX_TRIES - 2'h1) boot_r <= mtsc_pkg::BOOT_FAIL;
            else tries_r <= tries_r + 2'h1;
          end
        end
        mtsc_pkg::BOOT_RUN: if (!batt_s) boot_r <= mtsc_pkg::BOOT_IDLE;
        mtsc_pkg::BOOT_FAIL: ;
        default: boot_r <= mtsc_pkg::BOOT_IDLE;
      endcase
    end
  end
  assign boot_fail = (boot_r == mtsc_pkg::BOOT_FAIL);

  // Load start is a pulse on entry to each attempt, so the memory master restarts cleanly.
  logic loading_d_r;
  logic [1:0] tries_d_r;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      loading_d_r <= 1'b0;
      tries_d_r <= 2'h0;
      o_cfg_load_start <= 1'b0;
    end else begin
      loading_d_r <= (boot_r == mtsc_pkg::BOOT_LOAD);
      tries_d_r <= tries_r;
      o_cfg_load_start <= (boot_r == mtsc_pkg::BOOT_LOAD) &&
                          (!loading_d_r || tries_d_r != tries_r);
    end
  end

  // Battery error stays until the controller clears it; a new fault wins over the clear.
  logic bat_err_r;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) bat_err_r <= 1'b0;
    else if (bfault_s) bat_err_r <= 1'b1;
    else if (i_clear_status_cmd) bat_err_r <= 1'b0;
  end

  // Working state machine; frozen in parallel mode where it does not apply.
  mtsc_pkg::mtsc_state_type state_r;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r <= mtsc_pkg::ST_POWER_ON;
    end else if (par_s) begin
      state_r <= state_r;
    end else if (pre_rise) begin
      state_r <= mtsc_pkg::ST_POWER_ON;
    end else if (i_sleep_cmd) begin
      state_r <= mtsc_pkg::ST_SLEEP;
    end else begin
      case (state_r)
        mtsc_pkg::ST_POWER_ON, mtsc_pkg::ST_ACTIVE, mtsc_pkg::ST_BATTERY,
        mtsc_pkg::ST_NO_MAGNET: begin
          if (state_r == mtsc_pkg::ST_POWER_ON && boot_r != mtsc_pkg::BOOT_RUN)
            state_r <= mtsc_pkg::ST_POWER_ON;
          else if (low_s) state_r <= mtsc_pkg::ST_NO_MAGNET;
          else if (main_s) state_r <= mtsc_pkg::ST_ACTIVE;
          else state_r <= mtsc_pkg::ST_BATTERY;
        end
        mtsc_pkg::ST_SLEEP: ;
        default: state_r <= mtsc_pkg::ST_POWER_ON;
      endcase
    end
  end

  // Tracking and readout qualities by state; error only while main supply is present.
  logic readout_ok;
  logic state_err;
  always_comb begin
    readout_ok = 1'b0;
    state_err = 1'b0;
    case (state_r)
      mtsc_pkg::ST_ACTIVE: readout_ok = 1'b1;
      mtsc_pkg::ST_NO_MAGNET: begin
        readout_ok = main_s;
        state_err = main_s;
      end
      mtsc_pkg::ST_BATTERY: readout_ok = 1'b0;
      default: state_err = main_s;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_track_en <= 1'b0;
      o_track_fast <= 1'b0;
      o_readout_valid <= 1'b0;
      o_error_out_n <= 1'b1;
      o_state_flags <= 5'h00;
    end else begin
      o_track_en <= par_s || (state_r == mtsc_pkg::ST_ACTIVE) ||
                    (state_r == mtsc_pkg::ST_BATTERY) || (state_r == mtsc_pkg::ST_NO_MAGNET);
      o_track_fast <= (state_r == mtsc_pkg::ST_ACTIVE) || (state_r == mtsc_pkg::ST_BATTERY);
      o_readout_valid <= readout_ok;
      o_error_out_n <= ~(boot_fail || bat_err_r || (state_err && !par_s));
      o_state_flags <= {state_r == mtsc_pkg::ST_SLEEP, state_r == mtsc_pkg::ST_NO_MAGNET,
                        state_r == mtsc_pkg::ST_ACTIVE, state_r == mtsc_pkg::ST_POWER_ON,
                        state_r == mtsc_pkg::ST_BATTERY};
    end
  end

  // Period within revolution, revolution counter and even sector mapping.
  logic [7:0] period_r;
  logic [MT_WIDTH-1:0] turns_r;
  logic period_mode;
  logic [10:0] sector_prod;
  logic [8:0] ppr;
  assign ppr = {1'b0, period_count_config_r} + 9'h001;
  assign period_mode = stream_output_config_r[`MTSC_PERIOD_OUT_BIT] &&
                       (period_count_config_r != 8'h00);
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      period_r <= 8'h00;
      turns_r <= '0;
    end else if (i_period_tick && o_track_en) begin
      if (!i_dir_down) begin
        if (period_r == period_count_config_r) begin
          period_r <= 8'h00;
          turns_r <= turns_r + 1'b1;
        end else period_r <= period_r + 8'h01;
      end else begin
        if (period_r == 8'h00) begin
          period_r <= period_count_config_r;
          turns_r <= turns_r - 1'b1;
        end else period_r <= period_r - 8'h01;
      end
    end
  end
  // Multiplying before dividing keeps the sectors even for odd period counts.
  assign sector_prod = 11'(({3'h0, period_r} * `MTSC_SECTORS) / {2'h0, ppr});

  // Readout word: all ones when invalid outside parallel mode; period in the low byte in period mode.
  logic [MT_WIDTH-1:0] pos_word;
  always_comb begin
    if (period_mode)
      pos_word = {turns_r[MT_WIDTH-`MTSC_PERIOD_LSBS-1:0], period_r};
    else
      pos_word = turns_r;
  end
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_position <= '1;
      o_sync_bits <= 3'h7;
    end else if (readout_ok || par_s) begin
      o_position <= pos_word;
      o_sync_bits <= sector_prod[2:0];
    end else begin
      o_position <= '1;
      o_sync_bits <= 3'h7;
    end
  end

  // Readout port, address match, scan selection and register readback.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_readout_on_twi <= 1'b0;
      o_twi_ack <= 1'b0;
      o_pole_width_select <= 2'h0;
      o_on_axis_enable <= 1'b0;
      o_cfg_conflict <= 1'b0;
      o_reg_rdata <= 8'h00;
      o_par_idle <= 1'b0;
    end else begin
      o_readout_on_twi <= twi_route_r;
      o_twi_ack <= slv_s && i_twi_addr_valid && (i_twi_addr == `MTSC_SLAVE_ADDR) && main_s;
      o_pole_width_select <= scan_mode_config_r[`MTSC_POLE_MSB:`MTSC_POLE_LSB];
      o_on_axis_enable <= scan_mode_config_r[`MTSC_ON_AXIS_ENABLE_BIT];
      o_cfg_conflict <= scan_mode_config_r[`MTSC_ON_AXIS_ENABLE_BIT] &&
        (scan_mode_config_r[`MTSC_POLE_MSB:`MTSC_POLE_LSB] != `MTSC_POLE_ON_AXIS_ENABLE_REQ);
      // Parallel mode: a preset starts one conversion, then the block idles.
      o_par_idle <= par_s && !pre_s;
      case (i_reg_addr)
        `MTSC_OFS_PERIOD_CFG: o_reg_rdata <= period_count_config_r;
        `MTSC_OFS_SCAN_CFG: o_reg_rdata <= scan_mode_config_r;
        `MTSC_OFS_STREAM_CFG: o_reg_rdata <= stream_output_config_r;
        default: o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // Checks on state, error and counting behaviour.
  sequence s_fail_load;
    (boot_r == mtsc_pkg::BOOT_LOAD) && i_cfg_load_done && !i_cfg_load_ok;
  endsequence
  load_retry_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    s_fail_load ##0 (tries_r == 2'h2) |=> boot_fail ##1 !o_error_out_n)
    else $error("third failed load did not flag error");
  invalid_ones_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (!readout_ok && !par_s) |=> (o_position == '1))
    else $error("invalid readout not all ones");
  sleep_entry_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_sleep_cmd && !par_s && !pre_rise) |=> (state_r == mtsc_pkg::ST_SLEEP) ##1 !o_track_en)
    else $error("sleep command ignored");
  preset_poweron_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (pre_rise && !par_s) |=> (state_r == mtsc_pkg::ST_POWER_ON))
    else $error("preset did not enter power-on");
  nomag_err_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (state_r == mtsc_pkg::ST_NO_MAGNET && main_s && !par_s) |=> !o_error_out_n)
    else $error("no-magnet error missing");
  turn_count_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_period_tick && o_track_en && !i_dir_down && period_r == period_count_config_r)
      |=> (turns_r == $past(turns_r) + 1'b1) && (period_r == 8'h00))
    else $error("revolution count did not advance");
  slave_route_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (pre_rise && slv_s) |=> (boot_r == mtsc_pkg::BOOT_RUN) ##1 o_readout_on_twi)
    else $error("slave preset did not route readout");
  active_valid_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (state_r == mtsc_pkg::ST_ACTIVE) |=> o_readout_valid && o_track_fast)
    else $error("active state not valid");
endmodule // mtsc_core

// ===== test/mtsc_cfg_mem.sv
// Behavioural configuration memory that answers the block's load attempts.
`timescale 1ns/1ns
module mtsc_cfg_mem (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_start,
  input wire logic [1:0] i_fail_cnt,
  input wire logic [3:0] i_delay,
  output logic o_done,
  output logic o_ok,
  output logic [2:0] o_tries
);
  logic [3:0] wait_r;
  logic busy_r;
  logic ok_r;
  logic flip_r;
  // The result line is only meaningful with done, so it toggles otherwise to expose sloppy sampling.
  assign o_ok = o_done ? ok_r : flip_r;
  // Each start is answered after the set delay; the first i_fail_cnt attempts fail.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_r <= 1'b0;
      wait_r <= 4'h0;
      o_done <= 1'b0;
      ok_r <= 1'b0;
      flip_r <= 1'b0;
      o_tries <= 3'h0;
    end else begin
      flip_r <= ~flip_r;
      o_done <= 1'b0;
      if (i_start) begin
        busy_r <= 1'b1;
        wait_r <= i_delay;
        o_tries <= o_tries + 3'h1;
      end else if (busy_r && wait_r == 4'h0) begin
        busy_r <= 1'b0;
        o_done <= 1'b1;
        ok_r <= (o_tries > {1'b0, i_fail_cnt});
      end else if (busy_r) begin
        wait_r <= wait_r - 4'h1;
      end
    end
  end
endmodule // mtsc_cfg_mem

// ===== test/mtsc_core_tb_top.sv
// Self-checking testbench of the multiturn state and period block.
`timescale 1ns/1ns
`include "mtsc_defs.svh"
module mtsc_core_tb_top;
  logic i_clock, i_nrst, mem_nrst, i_main_supply, i_battery_ok, i_low_field, i_preset;
  logic i_slave_mode, i_sleep_cmd, i_clear_status_cmd, i_period_tick, done, ok, i_reg_wr;
  logic i_twi_addr_valid, o_cfg_load_start, o_error_out_n, o_track_en, o_track_fast;
  logic i_parallel_mode, i_battery_fault, o_par_idle;
  logic o_readout_valid, o_readout_on_twi, o_twi_ack, o_on_axis_enable, o_cfg_conflict;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, d;
  logic [6:0] i_twi_addr;
  logic [39:0] o_position, p0;
  logic [4:0] o_state_flags;
  logic [2:0] o_sync_bits, tries, t0;
  logic [1:0] o_pole_width_select, fail_cnt;
  logic [3:0] dly;
  int err_total, n_tests;
  mtsc_core #(.MT_WIDTH(40)) mtsc_core_i (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_main_supply(i_main_supply), .i_battery_ok(i_battery_ok), .i_low_field(i_low_field),
    .i_preset(i_preset), .i_parallel_mode(i_parallel_mode), .i_slave_mode(i_slave_mode),
    .i_sleep_cmd(i_sleep_cmd), .i_clear_status_cmd(i_clear_status_cmd),
    .i_battery_fault(i_battery_fault), .i_period_tick(i_period_tick), .i_dir_down(1'b0),
    .i_cfg_load_done(done), .i_cfg_load_ok(ok), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_twi_addr(i_twi_addr), .i_twi_addr_valid(i_twi_addr_valid),
    .o_reg_rdata(o_reg_rdata), .o_cfg_load_start(o_cfg_load_start),
    .o_error_out_n(o_error_out_n), .o_track_en(o_track_en), .o_track_fast(o_track_fast),
    .o_readout_valid(o_readout_valid), .o_readout_on_twi(o_readout_on_twi),
    .o_twi_ack(o_twi_ack), .o_position(o_position), .o_state_flags(o_state_flags),
    .o_sync_bits(o_sync_bits), .o_pole_width_select(o_pole_width_select),
    .o_on_axis_enable(o_on_axis_enable), .o_cfg_conflict(o_cfg_conflict),
    .o_par_idle(o_par_idle));
  mtsc_cfg_mem mtsc_cfg_mem_i (.i_clock(i_clock), .i_nrst(mem_nrst), .i_start(o_cfg_load_start),
    .i_fail_cnt(fail_cnt), .i_delay(dly), .o_done(done), .o_ok(ok), .o_tries(tries));
  // Free-running 25 MHz clock.
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  task automatic end_sim();
    if (err_total == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk_vec(input logic [39:0] got, input logic [39:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    i_reg_addr = a;
    i_reg_wdata = v;
    i_reg_wr = 1'b1;
    cyc(1);
    i_reg_wr = 1'b0;
    cyc(1);
  endtask
  task automatic reg_chk(input logic [7:0] a, input logic [7:0] v);
    i_reg_addr = a;
    cyc(2);
    chk_vec({32'h0, o_reg_rdata}, {32'h0, v}, "rdata");
  endtask
  // The pin stays high long enough to pass the synchroniser and its edge detector.
  task automatic preset();
    i_preset = 1'b1;
    cyc(6);
    i_preset = 1'b0;
    cyc(6);
  endtask
  task automatic tick();
    i_period_tick = 1'b1;
    cyc(1);
    i_period_tick = 1'b0;
    cyc(1);
  endtask
  // Watchdog at 10,000 cycles, well beyond the few hundred the sequence needs.
  initial begin
    #400000;
    err_total++;
    end_sim();
  end
  // Main sequence; inputs change at the falling edge only.
  initial begin
    {i_nrst, mem_nrst, i_low_field, i_preset, i_slave_mode, i_sleep_cmd} = 6'h00;
    {i_parallel_mode, i_battery_fault} = 2'h0;
    {i_clear_status_cmd, i_period_tick, i_reg_wr, i_twi_addr_valid} = 4'h0;
    {i_main_supply, i_battery_ok, i_reg_addr, i_reg_wdata, i_twi_addr} = 25'h1800000;
    {fail_cnt, dly, err_total, n_tests} = 0;
    void'($urandom(24041));
    cyc(8);
    {i_nrst, mem_nrst} = 2'h3;
    cyc(4);
    chk_vec(o_error_out_n, 0, "err");
    chk_vec(o_state_flags, 5'h02, "flags");
    chk_vec(o_position, {40{1'b1}}, "pos");
    d = $urandom;
    reg_wr(`MTSC_OFS_PERIOD_CFG, d);
    reg_chk(`MTSC_OFS_PERIOD_CFG, d);
    reg_wr(8'h03, 8'h5a);
    reg_chk(8'h03, 8'h00);
    for (int c = 0; c < 4; c++) begin
      reg_wr(`MTSC_OFS_SCAN_CFG, {5'h0, 1'b1, c[1:0]});
      chk_vec(o_pole_width_select, c, "pole");
      chk_vec({o_on_axis_enable, o_cfg_conflict}, {1'b1, c != 1}, "on_axis_enable");
    end
    i_main_supply = 1'b0;
    cyc(6);
    reg_wr(`MTSC_OFS_PERIOD_CFG, ~d);
    i_main_supply = 1'b1;
    cyc(6);
    reg_chk(`MTSC_OFS_PERIOD_CFG, d);
    fail_cnt = 2'h3;
    dly = $urandom_range(7);
    preset();
    for (int k = 0; k < 300 && o_error_out_n !== 1'b0; k++) cyc(1);
    cyc(60);
    chk_vec(o_error_out_n, 0, "err");
    chk_vec(tries, 3, "tries");
    // Without main supply only the failed load can hold the error output low.
    i_main_supply = 1'b0;
    cyc(6);
    chk_vec(o_error_out_n, 0, "fail err");
    chk_vec(tries, 3, "no retry");
    i_main_supply = 1'b1;
    cyc(6);
    mem_nrst = 1'b0;
    cyc(1);
    {mem_nrst, fail_cnt} = 3'h4;
    preset();
    for (int k = 0; k < 300 && o_error_out_n !== 1'b1; k++) cyc(1);
    cyc(10);
    chk_vec(o_state_flags, 5'h04, "flags");
    chk_vec({o_track_en, o_track_fast, o_readout_valid}, 3'h7, "trk");
    reg_wr(`MTSC_OFS_PERIOD_CFG, 8'h02);
    reg_wr(`MTSC_OFS_STREAM_CFG, 8'h00);
    p0 = o_position;
    repeat (3) tick();
    cyc(4);
    chk_vec(o_position, p0 + 1, "turn");
    reg_wr(`MTSC_OFS_STREAM_CFG, 8'h40);
    tick();
    cyc(4);
    p0 = p0 + 1;
    chk_vec(o_position, {p0[31:0], 8'h01}, "pcr");
    chk_vec(o_sync_bits, 2, "sync");
    i_main_supply = 1'b0;
    cyc(8);
    chk_vec(o_state_flags, 5'h01, "flags");
    chk_vec({o_track_en, o_readout_valid}, 2'h2, "bat");
    chk_vec(o_position, {40{1'b1}}, "pos");
    i_main_supply = 1'b1;
    cyc(8);
    chk_vec(o_state_flags, 5'h04, "flags");
    i_low_field = 1'b1;
    cyc(8);
    chk_vec(o_state_flags, 5'h08, "flags");
    chk_vec({o_track_fast, o_error_out_n}, 2'h0, "nomag");
    i_low_field = 1'b0;
    i_sleep_cmd = 1'b1;
    cyc(1);
    i_sleep_cmd = 1'b0;
    cyc(8);
    chk_vec(o_state_flags, 5'h10, "flags");
    chk_vec({o_track_en, o_error_out_n}, 2'h0, "sleep");
    chk_vec(o_position, {40{1'b1}}, "pos");
    t0 = tries;
    i_slave_mode = 1'b1;
    cyc(4);
    preset();
    cyc(8);
    chk_vec({o_readout_on_twi, tries}, {1'b1, t0}, "slave");
    for (int k = 0; k < 8; k++) begin
      i_twi_addr = (k == 0) ? `MTSC_SLAVE_ADDR : `MTSC_SLAVE_ADDR ^ 7'($urandom_range(1, 127));
      i_twi_addr_valid = 1'b1;
      cyc(2);
      chk_vec(o_twi_ack, i_twi_addr == `MTSC_SLAVE_ADDR, "ack");
      i_twi_addr_valid = 1'b0;
      cyc(2);
    end
    // A battery fault latches the error until the controller clears it.
    i_battery_fault = 1'b1;
    cyc(4);
    i_battery_fault = 1'b0;
    cyc(4);
    chk_vec(o_error_out_n, 0, "bat err");
    i_clear_status_cmd = 1'b1;
    cyc(1);
    i_clear_status_cmd = 1'b0;
    cyc(2);
    chk_vec(o_error_out_n, 1, "clear");
    // Parallel mode freezes the working state and answers a preset with a position.
    i_slave_mode = 1'b0;
    i_parallel_mode = 1'b1;
    cyc(4);
    i_low_field = 1'b1;
    cyc(8);
    chk_vec(o_state_flags, 5'h04, "par frz");
    chk_vec({o_track_en, o_error_out_n, o_par_idle}, 3'h7, "par");
    i_preset = 1'b1;
    cyc(6);
    chk_vec(o_par_idle, 0, "par busy");
    i_preset = 1'b0;
    cyc(6);
    chk_vec(o_par_idle, 1, "par idle");
    chk_vec(o_position, {p0[31:0], 8'h01}, "par pos");
    chk_vec(o_state_flags, 5'h04, "par frz");
    end_sim();
  end
endmodule // mtsc_core_tb_top
